// *** light_sensor_pkg.sv ***
package light_sensor_pkg;

    // Register map indices
    localparam logic [3:0] ADDR_CMD1      = 4'h0;
    localparam logic [3:0] ADDR_CMD2      = 4'h1;
    localparam logic [3:0] ADDR_RESULT_LO = 4'h2;
    localparam logic [3:0] ADDR_RESULT_HI = 4'h3;
    localparam logic [3:0] ADDR_LT_LO     = 4'h4;
    localparam logic [3:0] ADDR_LT_HI     = 4'h5;
    localparam logic [3:0] ADDR_UT_LO     = 4'h6;
    localparam logic [3:0] ADDR_UT_HI     = 4'h7;
    localparam logic [3:0] ADDR_TEST      = 4'h8;
    localparam logic [3:0] ADDR_LAST      = ADDR_TEST;

    // Field positions
    localparam int CMD1_MODE_LSB    = 5;
    localparam int CMD1_FLAG_BIT    = 2;
    localparam int CMD1_PERSIST_LSB = 0;
    localparam int CMD2_WIDTH_LSB   = 2;
    localparam int CMD2_SPAN_LSB    = 0;

    // Reset values
    localparam logic [2:0] MODE_RESET    = 3'h0;
    localparam logic [1:0] PERSIST_RESET = 2'h0;
    localparam logic [1:0] WIDTH_RESET   = 2'h0;
    localparam logic [1:0] SPAN_RESET    = 2'h0;
    localparam logic [7:0] RESULT_RESET  = 8'h00;
    localparam logic [7:0] LT_RESET      = 8'h00;
    localparam logic [7:0] UT_RESET      = 8'hff;
    localparam logic [7:0] TEST_VALUE    = 8'h00;

    // Timing
    localparam int CLK_PERIOD_NS     = 4;
    localparam int POR_SETTLE_NS     = 100;
    localparam int POR_SETTLE_CYCLES = (POR_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam logic [3:0] BYTE_BITS = 4'h8;

    typedef struct packed {
        logic [2:0] modeSel;
        logic [1:0] persistSel;
        logic [1:0] adcWidthSel;
        logic [1:0] spanSel;
    } sensor_cfg_s;

    typedef enum logic [3:0] {
        LINK_IDLE     = 4'b0000,
        LINK_DEVADDR  = 4'b0001,
        LINK_ADDR_ACK = 4'b0010,
        LINK_REGADDR  = 4'b0011,
        LINK_REG_ACK  = 4'b0100,
        LINK_WRDATA   = 4'b0101,
        LINK_WR_ACK   = 4'b0110,
        LINK_TX       = 4'b0111,
        LINK_MACK     = 4'b1000,
        LINK_WAITSTOP = 4'b1001
    } link_state_e;

    // Auto-increment with roll-over past the last register
    function automatic logic [3:0] nextAddr(input logic [3:0] a);
        if (a >= ADDR_LAST) begin
            return ADDR_CMD1;
        end
        return a + 4'h1;
    endfunction

    // Persistence code to consecutive out-of-window count
    function automatic logic [4:0] persistCount(input logic [1:0] code);
        case (code)
            2'h0:    return 5'h01;
            2'h1:    return 5'h04;
            2'h2:    return 5'h08;
            default: return 5'h10;
        endcase
    endfunction

endpackage

// *** conv_result_sync.sv ***
`timescale 1ns/1ps
module conv_result_sync
    import light_sensor_pkg::*;
(
    input  wire logic        convClk,
    input  wire logic        rst_b,
    input  wire logic        convDone,
    input  wire logic [15:0] convResult,
    input  wire logic        clk,
    output logic             resultValid,
    output logic      [15:0] result
);

    logic [15:0] hold_r;
    logic        tgl_r;
    logic [2:0]  tglSync_r;

    // Converter side: word held stable while toggle crosses
    always_ff @(posedge convClk or negedge rst_b) begin
        if (!rst_b) begin
            hold_r <= 16'h0000;
            tgl_r  <= 1'b0;
        end else if (convDone) begin
            hold_r <= convResult;
            tgl_r  <= ~tgl_r;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tglSync_r <= 3'h0;
        end else begin
            tglSync_r <= {tglSync_r[1:0], tgl_r};
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            result      <= {RESULT_RESET, RESULT_RESET};
            resultValid <= 1'b0;
        end else begin
            resultValid <= tglSync_r[2] ^ tglSync_r[1];
            if (tglSync_r[2] ^ tglSync_r[1]) begin
                result <= hold_r;
            end
        end
    end

endmodule

// *** light_sensor_i2c_regs_irq.sv ***
`timescale 1ns/1ps
// Behaviour
// - Every received byte is acked unless the device address differs; each write data byte advances the pointer by one.
// - After a write burst the pointer rests on the last written address.
// - Pointer rolls over from the last register back to address zero.
// - Byte read: write phase sets address, restart with read returns data.
// - Each acked read byte is followed by another; a nack stops driving.
// - Reset refuses all register access; release enters standby.
// - Serial access is blocked until power-on settling completes.
// - First control register is zero after power-on.
// - Persistence code selects 1, 4, 8 or 16 consecutive out-of-window results.
// - Mode and persistence fields are stored and act independently.
// - Interrupt pin is active low and stays until cleared.
// - Interrupt flag reads at bit 2 of the first control register.
// - Flag and pin assert together when the selected count of consecutive out-of-window results is reached.
// - Flag and pin clear when a byte of register zero completes transfer.
// - Out of window means at or below lower, or at or above upper.
// - Conversion results keep updating after an interrupt.
// - Bits 7:5 select the operating mode.
module light_sensor_i2c_regs_irq
    import light_sensor_pkg::*;
#(
    parameter logic [6:0] DEV_ID = 7'h2a  // Arbitrary bus identifier
) (
    input  wire logic         clk,
    input  wire logic         rst_b,
    input  wire logic         convClk,
    input  wire logic         convDone,
    input  wire logic  [15:0] convResult,
    input  wire logic         sclIn,
    input  wire logic         sdaIn,
    output logic              sdaOut,
    output logic              sdaOe,
    output logic              intPinOut,
    output logic              intPinOe,
    output sensor_cfg_s       cfg
);

    localparam int         POR_CNT_W = $clog2(POR_SETTLE_CYCLES + 1);
    localparam logic [POR_CNT_W-1:0] POR_LAST = POR_CNT_W'(POR_SETTLE_CYCLES - 1);

    // Pin synchronisers
    logic [1:0]  sclSync_r;
    logic [1:0]  sdaSync_r;
    logic        sclPrev_r;
    logic        sdaPrev_r;
    logic        sclS;
    logic        sdaS;
    logic        sclRise;
    logic        sclFall;
    logic        startCond;
    logic        stopCond;

    // Power-on settling
    logic [POR_CNT_W-1:0] porCnt_r;
    logic                 porDone_r;

    // Link state
    link_state_e state_r;
    logic [3:0]  bitCnt_r;
    logic [7:0]  shift_r;
    logic [7:0]  tx_r;
    logic [3:0]  ptr_r;
    logic [3:0]  lastWr_r;
    logic        wrote_r;
    logic        isRead_r;
    logic        masterAck_r;
    logic        sdaOe_r;

    // Registers
    logic [2:0]  modeSel_r;
    logic [1:0]  persistSel_r;
    logic [1:0]  adcWidthSel_r;
    logic [1:0]  spanSel_r;
    logic [15:0] lowerThr_r;
    logic [15:0] upperThr_r;
    logic        flag_r;
    logic [4:0]  persistCnt_r;

    logic [15:0] result;
    logic        resultValid;
    logic [7:0]  rdData;
    logic        byteEnd;
    logic        wrEn;
    logic        clrFlag;
    logic        outside;
    logic        setFlag;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sclSync_r <= 2'h3;
            sdaSync_r <= 2'h3;
            sclPrev_r <= 1'b1;
            sdaPrev_r <= 1'b1;
        end else begin
            sclSync_r <= {sclSync_r[0], sclIn};
            sdaSync_r <= {sdaSync_r[0], sdaIn};
            sclPrev_r <= sclSync_r[1];
            sdaPrev_r <= sdaSync_r[1];
        end
    end

    assign sclS      = sclSync_r[1];
    assign sdaS      = sdaSync_r[1];
    assign sclRise   = sclS & ~sclPrev_r;
    assign sclFall   = ~sclS & sclPrev_r;
    assign startCond = sclS & sclPrev_r & sdaPrev_r & ~sdaS;
    assign stopCond  = sclS & sclPrev_r & ~sdaPrev_r & sdaS;
    assign byteEnd   = sclFall && (bitCnt_r == BYTE_BITS);

    // Settling window after reset release
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            porCnt_r  <= '0;
            porDone_r <= 1'b0;
        end else if (!porDone_r) begin
            if (porCnt_r == POR_LAST) begin
                porDone_r <= 1'b1;
            end else begin
                porCnt_r <= porCnt_r + 1'b1;
            end
        end
    end

    // Link state machine
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_r     <= LINK_IDLE;
            bitCnt_r    <= 4'h0;
            shift_r     <= 8'h00;
            tx_r        <= 8'h00;
            ptr_r       <= ADDR_CMD1;
            lastWr_r    <= ADDR_CMD1;
            wrote_r     <= 1'b0;
            isRead_r    <= 1'b0;
            masterAck_r <= 1'b0;
            sdaOe_r     <= 1'b0;
        end else if (!porDone_r) begin
            state_r <= LINK_IDLE;
            sdaOe_r <= 1'b0;
        end else if (startCond || stopCond) begin
            state_r  <= startCond ? LINK_DEVADDR : LINK_IDLE;
            bitCnt_r <= 4'h0;
            sdaOe_r  <= 1'b0;
            wrote_r  <= 1'b0;
            if (wrote_r) begin
                ptr_r <= lastWr_r;
            end
        end else begin
            case (state_r)
                LINK_DEVADDR, LINK_REGADDR, LINK_WRDATA: begin
                    if (sclRise && bitCnt_r != BYTE_BITS) begin
                        shift_r  <= {shift_r[6:0], sdaS};
                        bitCnt_r <= bitCnt_r + 4'h1;
                    end else if (byteEnd) begin
                        bitCnt_r <= 4'h0;
                        if (state_r == LINK_DEVADDR) begin
                            if (shift_r[7:1] == DEV_ID) begin
                                sdaOe_r  <= 1'b1;
                                isRead_r <= shift_r[0];
                                state_r  <= LINK_ADDR_ACK;
                            end else begin
                                state_r <= LINK_WAITSTOP;
                            end
                        end else if (state_r == LINK_REGADDR) begin
                            sdaOe_r <= 1'b1;
                            ptr_r   <= (shift_r > {4'h0, ADDR_LAST}) ? ADDR_CMD1 : shift_r[3:0];
                            state_r <= LINK_REG_ACK;
                        end else begin
                            sdaOe_r  <= 1'b1;
                            lastWr_r <= ptr_r;
                            wrote_r  <= 1'b1;
                            ptr_r    <= nextAddr(ptr_r);
                            state_r  <= LINK_WR_ACK;
                        end
                    end
                end
                LINK_ADDR_ACK: begin
                    if (sclFall) begin
                        if (isRead_r) begin
                            tx_r     <= rdData;
                            sdaOe_r  <= ~rdData[7];
                            bitCnt_r <= 4'h0;
                            state_r  <= LINK_TX;
                        end else begin
                            sdaOe_r <= 1'b0;
                            state_r <= LINK_REGADDR;
                        end
                    end
                end
                LINK_REG_ACK, LINK_WR_ACK: begin
                    if (sclFall) begin
                        sdaOe_r <= 1'b0;
                        state_r <= LINK_WRDATA;
                    end
                end
                LINK_TX: begin
                    if (sclRise) begin
                        bitCnt_r <= bitCnt_r + 4'h1;
                    end else if (byteEnd) begin
                        sdaOe_r <= 1'b0;
                        state_r <= LINK_MACK;
                    end else if (sclFall) begin
                        tx_r    <= {tx_r[6:0], 1'b0};
                        sdaOe_r <= ~tx_r[6];
                    end
                end
                LINK_MACK: begin
                    if (sclRise) begin
                        masterAck_r <= ~sdaS;
                        if (!sdaS) begin
                            ptr_r <= nextAddr(ptr_r);
                        end
                    end else if (sclFall) begin
                        bitCnt_r <= 4'h0;
                        if (masterAck_r) begin
                            tx_r    <= rdData;
                            sdaOe_r <= ~rdData[7];
                            state_r <= LINK_TX;
                        end else begin
                            sdaOe_r <= 1'b0;
                            state_r <= LINK_WAITSTOP;
                        end
                    end
                end
                LINK_IDLE, LINK_WAITSTOP: begin
                    sdaOe_r <= 1'b0;
                end
                default: begin
                    state_r <= LINK_IDLE;
                    sdaOe_r <= 1'b0;
                end
            endcase
        end
    end

    assign sdaOut = 1'b0;
    assign sdaOe  = sdaOe_r;

    assign wrEn    = (state_r == LINK_WRDATA) && byteEnd && porDone_r;
    assign clrFlag = porDone_r && byteEnd && (ptr_r == ADDR_CMD1)
                     && (state_r == LINK_WRDATA || state_r == LINK_TX);

    // Read data for the byte at the pointer
    always_comb begin
        case (ptr_r)
            ADDR_CMD1:      rdData = {modeSel_r, 2'b00, flag_r, persistSel_r};
            ADDR_CMD2:      rdData = {4'h0, adcWidthSel_r, spanSel_r};
            ADDR_RESULT_LO: rdData = result[7:0];
            ADDR_RESULT_HI: rdData = result[15:8];
            ADDR_LT_LO:     rdData = lowerThr_r[7:0];
            ADDR_LT_HI:     rdData = lowerThr_r[15:8];
            ADDR_UT_LO:     rdData = upperThr_r[7:0];
            ADDR_UT_HI:     rdData = upperThr_r[15:8];
            ADDR_TEST:      rdData = TEST_VALUE;
            default:        rdData = 8'h00;
        endcase
    end

    // Register writes; flag, reserved and read-only bits ignore writes
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            modeSel_r     <= MODE_RESET;
            persistSel_r  <= PERSIST_RESET;
            adcWidthSel_r <= WIDTH_RESET;
            spanSel_r     <= SPAN_RESET;
            lowerThr_r    <= {LT_RESET, LT_RESET};
            upperThr_r    <= {UT_RESET, UT_RESET};
        end else if (wrEn) begin
            case (ptr_r)
                ADDR_CMD1: begin
                    modeSel_r    <= shift_r[CMD1_MODE_LSB +: 3];
                    persistSel_r <= shift_r[CMD1_PERSIST_LSB +: 2];
                end
                ADDR_CMD2: begin
                    adcWidthSel_r <= shift_r[CMD2_WIDTH_LSB +: 2];
                    spanSel_r     <= shift_r[CMD2_SPAN_LSB +: 2];
                end
                ADDR_LT_LO: lowerThr_r[7:0]  <= shift_r;
                ADDR_LT_HI: lowerThr_r[15:8] <= shift_r;
                ADDR_UT_LO: upperThr_r[7:0]  <= shift_r;
                ADDR_UT_HI: upperThr_r[15:8] <= shift_r;
                default: begin
                end
            endcase
        end
    end

    assign cfg.modeSel     = modeSel_r;
    assign cfg.persistSel  = persistSel_r;
    assign cfg.adcWidthSel = adcWidthSel_r;
    assign cfg.spanSel     = spanSel_r;

    // Results keep arriving regardless of the flag
    conv_result_sync u_sync (
        .convClk     (convClk),
        .rst_b       (rst_b),
        .convDone    (convDone),
        .convResult  (convResult),
        .clk         (clk),
        .resultValid (resultValid),
        .result      (result)
    );

    assign outside = (result <= lowerThr_r) || (result >= upperThr_r);
    assign setFlag = resultValid && outside
                     && ((persistCnt_r + 5'h01) >= persistCount(persistSel_r));

    // Consecutive out-of-window count, saturating
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            persistCnt_r <= 5'h00;
        end else if (resultValid) begin
            if (!outside) begin
                persistCnt_r <= 5'h00;
            end else if (persistCnt_r != 5'h10) begin
                persistCnt_r <= persistCnt_r + 5'h01;
            end
        end
    end

    // Set wins over a simultaneous clear
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            flag_r <= 1'b0;
        end else begin
            flag_r <= setFlag | (flag_r & ~clrFlag);
        end
    end

    assign intPinOut = 1'b0;
    assign intPinOe  = flag_r;

endmodule

// *** light_sensor_props.sv ***
`timescale 1ns/1ps
module light_sensor_props
    import light_sensor_pkg::*;
(
    input wire logic        clk,
    input wire logic        rst_b,
    input wire logic        convClk,
    input wire logic        convDone,
    input wire logic [15:0] convResult,
    input wire logic        sclIn,
    input wire logic        sdaIn,
    input wire logic        sdaOut,
    input wire logic        sdaOe,
    input wire logic        intPinOut,
    input wire logic        intPinOe,
    input wire sensor_cfg_s cfg
);
    logic [5:0] settleCnt_r;
    logic [4:0] convAge_r;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            settleCnt_r <= 6'h00;
        end else if (settleCnt_r < 6'h28) begin
            settleCnt_r <= settleCnt_r + 6'h01;
        end
    end

    // Cycles since a conversion strobe was last seen
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            convAge_r <= 5'h1f;
        end else if (convDone) begin
            convAge_r <= 5'h00;
        end else if (convAge_r != 5'h1f) begin
            convAge_r <= convAge_r + 5'h01;
        end
    end

    chk_release_idle: assert property ($rose(rst_b) |-> !sdaOe && !intPinOe && cfg == '0)
        else $error("outputs not idle after reset");
    chk_settle_quiet: assert property (settleCnt_r < POR_SETTLE_CYCLES |-> !sdaOe)
        else $error("bus answered before settling");
    chk_open_drain: assert property (!sdaOut && !intPinOut)
        else $error("open drain pin driven high");
    chk_sda_scl_low: assert property ($changed(sdaOe) |-> !sclIn)
        else $error("data changed while clock high");
    chk_drive_after_fall: assert property ($rose(sdaOe) |-> !$past(sclIn) && !$past(sclIn, 2))
        else $error("data driven too early");
    chk_cfg_scl_low: assert property ($changed(cfg) |-> !sclIn)
        else $error("config changed outside a byte end");
    chk_int_sticky: assert property ($fell(intPinOe) |-> !sclIn && !$past(sclIn))
        else $error("interrupt released without transfer");
    chk_int_cause: assert property ($rose(intPinOe) |-> convAge_r <= 5'h10)
        else $error("interrupt without a new result");
endmodule

bind light_sensor_i2c_regs_irq light_sensor_props light_sensor_props_i (
    .clk(clk), .rst_b(rst_b), .convClk(convClk), .convDone(convDone),
    .convResult(convResult), .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut),
    .sdaOe(sdaOe), .intPinOut(intPinOut), .intPinOe(intPinOe), .cfg(cfg)
);

// *** i2c_ctrl_model.sv ***
`timescale 1ns/1ps
module i2c_ctrl_model (
    input  wire logic clk,
    input  wire logic sdaLine,
    output logic      sclLine,
    output logic      sdaPull
);
    localparam int HALF = 6;

    initial begin
        sclLine = 1'b1;
        sdaPull = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic putBit(input logic b);
        tick(2);
        sdaPull <= !b;
        tick(HALF - 2);
        sclLine <= 1'b1;
        tick(HALF);
        sclLine <= 1'b0;
    endtask

    task automatic getBit(output logic b);
        tick(2);
        sdaPull <= 1'b0;
        tick(HALF - 2);
        sclLine <= 1'b1;
        tick(3);
        b = sdaLine;
        tick(HALF - 3);
        sclLine <= 1'b0;
    endtask

    // Also serves as repeated start
    task automatic start();
        tick(2);
        sdaPull <= 1'b0;
        tick(HALF - 2);
        sclLine <= 1'b1;
        tick(HALF);
        sdaPull <= 1'b1;
        tick(HALF);
        sclLine <= 1'b0;
    endtask

    task automatic stop();
        tick(2);
        sdaPull <= 1'b1;
        tick(HALF - 2);
        sclLine <= 1'b1;
        tick(HALF);
        sdaPull <= 1'b0;
        tick(HALF);
    endtask

    task automatic putByte(input logic [7:0] d, output logic ack);
        logic b;
        for (int i = 7; i >= 0; i--) putBit(d[i]);
        getBit(b);
        ack = !b;
    endtask

    task automatic getByte(input logic more, output logic [7:0] d);
        for (int i = 7; i >= 0; i--) getBit(d[i]);
        putBit(!more);
    endtask
endmodule

// *** light_sensor_i2c_regs_irq_test.sv ***
`timescale 1ns/1ps
module light_sensor_i2c_regs_irq_test;
    import light_sensor_pkg::*;
    localparam logic [6:0] DEV = 7'h2a;  // Arbitrary bus identifier
    logic        clk, rst_b, convClk, convDone, sdaOut, sdaOe, intPinOut, intPinOe;
    logic        scl, sdaPull, ack, expFlag;
    logic [15:0] convResult, lt, ut, v;
    logic [7:0]  regMirror [9];
    logic [7:0]  c1;
    logic [2:0]  modes [5] = '{3'h0, 3'h1, 3'h2, 3'h5, 3'h6};
    sensor_cfg_s cfg;
    int          fails, checks, n;
    int          seed = 32'hcdfd;
    wire         sda = !(sdaPull || sdaOe);

    light_sensor_i2c_regs_irq #(.DEV_ID(DEV)) light_sensor_i2c_regs_irq_i (
        .clk(clk), .rst_b(rst_b), .convClk(convClk), .convDone(convDone),
        .convResult(convResult), .sclIn(scl), .sdaIn(sda), .sdaOut(sdaOut),
        .sdaOe(sdaOe), .intPinOut(intPinOut), .intPinOe(intPinOe), .cfg(cfg));
    i2c_ctrl_model i2c_ctrl_model_i (.clk(clk), .sdaLine(sda), .sclLine(scl), .sdaPull(sdaPull));

    initial begin
        clk = 1'b0;
        forever #2 clk = !clk;
    end
    initial begin
        convClk = 1'b0;
        #7;
        forever #24 convClk = !convClk;
    end

    task automatic complete_run();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    function automatic logic [7:0] wmask(input logic [3:0] a);
        case (a)
            4'h0: return 8'he3;
            4'h1: return 8'h0f;
            4'h4, 4'h5, 4'h6, 4'h7: return 8'hff;
            default: return 8'h00;
        endcase
    endfunction

    function automatic logic [3:0] nxt(input logic [3:0] p);
        return (p >= 4'h8) ? 4'h0 : p + 4'h1;
    endfunction

    task automatic clearMirror();
        regMirror = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'hff, 8'h00};
        expFlag = 1'b0;
    endtask

    task automatic wrRegs(input logic [3:0] a, input logic [7:0] d[$]);
        logic [3:0] p;
        p = (a > 4'h8) ? 4'h0 : a;
        i2c_ctrl_model_i.start();
        i2c_ctrl_model_i.putByte({DEV, 1'b0}, ack);
        cmp({15'h0, ack}, 16'h1, "id ack");
        i2c_ctrl_model_i.putByte({4'h0, a}, ack);
        foreach (d[i]) begin
            i2c_ctrl_model_i.putByte(d[i], ack);
            cmp({15'h0, ack}, 16'h1, "data ack");
            regMirror[p] = (d[i] & wmask(p)) | (regMirror[p] & ~wmask(p));
            if (p == 4'h0) expFlag = 1'b0;
            p = nxt(p);
        end
        i2c_ctrl_model_i.stop();
    endtask

    task automatic rdCheck(input logic [3:0] a, input int cnt, input bit setAddr);
        logic [7:0] q;
        logic [3:0] p;
        p = (a > 4'h8) ? 4'h0 : a;
        if (setAddr) begin
            i2c_ctrl_model_i.start();
            i2c_ctrl_model_i.putByte({DEV, 1'b0}, ack);
            i2c_ctrl_model_i.putByte({4'h0, a}, ack);
        end
        i2c_ctrl_model_i.start();
        i2c_ctrl_model_i.putByte({DEV, 1'b1}, ack);
        cmp({15'h0, ack}, 16'h1, "read id ack");
        for (int i = 0; i < cnt; i++) begin
            i2c_ctrl_model_i.getByte(i < cnt - 1, q);
            cmp({8'h0, q}, {8'h0, regMirror[p] | (p == 4'h0 ? {5'h0, expFlag, 2'h0} : 8'h00)},
                "read byte");
            if (p == 4'h0) expFlag = 1'b0;
            p = nxt(p);
        end
        i2c_ctrl_model_i.stop();
        cmp({15'h0, intPinOe}, {15'h0, expFlag}, "int after read");
    endtask

    task automatic conv(input logic [15:0] val);
        @(posedge convClk);
        convDone <= 1'b1;
        convResult <= val;
        @(posedge convClk);
        convDone <= 1'b0;
        repeat (12) @(posedge clk);
        regMirror[2] = val[7:0];
        regMirror[3] = val[15:8];
    endtask

    initial begin
        repeat (60000) @(posedge clk);
        fails++;
        complete_run();
    end

    initial begin
        rst_b = 1'b0;
        convDone = 1'b0;
        convResult = 16'h0000;
        clearMirror();
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        // Traffic while settling is ignored
        i2c_ctrl_model_i.start();
        i2c_ctrl_model_i.putByte({DEV, 1'b0}, ack);
        cmp({15'h0, ack}, 16'h0, "early ack");
        i2c_ctrl_model_i.stop();
        rdCheck(4'h0, 10, 1'b1);
        rdCheck(4'hc, 2, 1'b1);
        for (int p = 0; p < 5; p++) begin
            lt = {1'b0, 15'($random(seed))} | 16'h0100;
            ut = lt + 16'h0010 + {4'h0, 12'($random(seed))};
            c1 = {modes[p], 3'b000, 2'(p)};
            n = (p % 4 == 0) ? 1 : (2 << (p % 4));
            wrRegs(4'h4, '{lt[7:0], lt[15:8], ut[7:0], ut[15:8], 8'h5a, c1,
                           {4'h0, 4'($random(seed))}});
            rdCheck(4'h1, 1, 1'b0);
            cmp({7'h0, cfg}, {7'h0, regMirror[0][7:5], regMirror[0][1:0], regMirror[1][3:0]},
                "cfg");
            // Clear any count left from the previous round
            conv(lt + 16'h0001);
            for (int k = 0; k < n - 1; k++) conv(k % 2 ? ut : lt);
            conv(lt + 16'h0001);
            for (int k = 0; k < n - 1; k++) conv(k % 2 ? lt : ut);
            cmp({15'h0, intPinOe}, 16'h0, "int early");
            conv(p % 2 ? lt : ut);
            expFlag = 1'b1;
            cmp({15'h0, intPinOe}, 16'h1, "int set");
            v = lt + 16'h0001 + {8'h0, 8'($random(seed))};
            conv(v);
            cmp({15'h0, intPinOe}, 16'h1, "int held");
            rdCheck(4'h0, 4, 1'b1);
            rdCheck(4'h0, 1, 1'b1);
        end
        conv(ut);
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        cmp({7'h0, cfg}, 16'h0, "cfg in reset");
        cmp({15'h0, intPinOe}, 16'h0, "int in reset");
        rst_b <= 1'b1;
        clearMirror();
        repeat (30) @(posedge clk);
        rdCheck(4'h0, 9, 1'b1);
        complete_run();
    end
endmodule
